// [logic/dcmw_pkg.sv]
// Shared constants and types for one end of the dual-computer mailbox and watchdog link.
// Assumes a single 125 MHz system clock for both boards and the host APB bus.
package dcmw_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 125_000_000;
   localparam int unsigned WDT_PERIOD_S   = 1;
   localparam int unsigned WDT_CYCLES_DEF = CLK_HZ * WDT_PERIOD_S;
   localparam int unsigned SETTLE_CYCLES  = 4;   // Must exceed cable sync latency

   // ---------------------------------------------------------------
   // Widths, device codes, register map
   // ---------------------------------------------------------------
   localparam int unsigned DATA_W   = 16;
   localparam int unsigned ADDR_W   = 12;
   localparam logic [5:0]  DEV_LINK = 6'h1E;     // Half-duplex line select code
   localparam logic [5:0]  DEV_WDT  = 6'h1F;     // Watchdog select code
   localparam logic [5:0]  DEV_NONE = 6'h00;

   localparam logic [ADDR_W-1:0] OFS_ACC      = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_CMD      = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_FLAGS    = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_BUF      = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_INT_STAT = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_INT_SRC  = 12'h018;

   // Flag register bit positions
   localparam int unsigned FLG_BUSY      = 0;
   localparam int unsigned FLG_DONE      = 1;
   localparam int unsigned FLG_WDT_DONE  = 2;
   localparam int unsigned FLG_WDT_RUN   = 3;
   localparam int unsigned FLG_PENDING   = 4;
   localparam int unsigned FLG_PEER_BUSY = 5;

   // Interrupt bits, listed in priority order
   localparam int unsigned INT_LINK = 0;
   localparam int unsigned INT_WDT  = 1;
   localparam int unsigned INT_N    = 2;
   localparam logic [INT_N-1:0] MASK_RST = 2'h0;

   // Cable event toggles
   localparam int unsigned EV_BUF    = 0;        // Buffer word written
   localparam int unsigned EV_BCLR   = 1;        // Clear peer busy
   localparam int unsigned EV_DSET   = 2;        // Set peer done
   localparam int unsigned EV_WSTART = 3;        // Restart peer watchdog
   localparam int unsigned EV_WSET   = 4;        // Set peer watchdog done
   localparam int unsigned EV_N      = 5;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {OP_NIO, OP_READ, OP_WRITE, OP_CLRF} dcmw_op_t;
   typedef enum logic [1:0] {FN_NONE, FN_START, FN_CLEAR, FN_PULSE} dcmw_fn_t;

   typedef struct packed {
      dcmw_fn_t   fn;
      dcmw_op_t   op;
      logic [5:0] dev;
   } dcmw_cmd_t;

   localparam int unsigned CMD_W = $bits(dcmw_cmd_t);

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [EV_N-1:0]   evt;
      logic              busy;
      logic              req;
   } dcmw_cable_t;

endpackage : dcmw_pkg

// [logic/dcmw_sync.sv]
// Two-stage synchroniser for a vector of cable signals.
// Assumes each bit is a level or a toggle that holds for several clocks.
`timescale 1ns/1ps
module dcmw_sync
   import dcmw_pkg::*;
#(
   parameter int unsigned W = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   // ---------------------------------------------------------------
   // Capture stages
   // ---------------------------------------------------------------
   // First stage feeds only the second one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : dcmw_sync

// [logic/dcmw_wdt.sv]
// Down-counting watchdog timer that flags expiry once per start.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module dcmw_wdt
   import dcmw_pkg::*;
#(
   parameter int unsigned CYCLES = WDT_CYCLES_DEF
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic start,
   output logic      running,
   output logic      expire
);

   localparam int unsigned CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt;

   // Expiry pulse on the last counted cycle
   assign expire = running && (cnt == '0);

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   // A restart reloads even a running timer; after expiry it stays idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt     <= '0;
         running <= 1'b0;
      end else if (start) begin
         cnt     <= CW'(CYCLES - 1);
         running <= 1'b1;
      end else if (expire) begin
         running <= 1'b0;
      end else if (running) begin
         cnt <= cnt - 1'b1;
      end
   end

endmodule : dcmw_wdt

// [logic/dcmw_link.sv]
// One end of the dual-computer link: shared word buffer with busy/done
// interlock, and the mutual watchdog, commanded by the host over APB.
// Assumes the peer board runs the same logic on the far end of the cable.
//
// How it works
// [RULE1] Read copies buffer into accumulator, buffer kept
// [RULE2] Write loads buffer from accumulator, accumulator kept
// [RULE3] Transfer then applies its start/clear/pulse function
// [RULE4] Clear-flags zeroes busy and done, accumulator lost
// [RULE5] Host never attaches function to clear-flags
// [RULE6] Expired watchdog raises local interrupt request
// [RULE7] Start on watchdog restarts the peer timer
// [RULE8] Expiry sets watchdog done flag
// [RULE9] Watchdog done stays until local clear
// [RULE10] Clear on watchdog zeroes own watchdog done
// [RULE11] Pulse on watchdog sets peer watchdog done
// [RULE12] Start-own-timer restarts own timer, accumulator kept
// [RULE13] Host restarts peer watchdog within each second
// [RULE14] Start sets busy only if peer idle
// [RULE15] Clear frees peer busy; pulse sets peer done
// [RULE16] Line interrupt outranks watchdog interrupt
// [RULE17] Watchdog answers only its own select code
// [RULE18] Watchdog interrupt follows its done flag
`timescale 1ns/1ps
module dcmw_link
   import dcmw_pkg::*;
#(
   parameter int unsigned WDT_CYCLES = WDT_CYCLES_DEF,
   parameter int unsigned SETTLE     = SETTLE_CYCLES,
   parameter bit          ARB_WINS   = 1'b0
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   irq,
   output dcmw_cable_t            cable_out,
   input  wire dcmw_cable_t       cable_in
);

   localparam int unsigned SW = $clog2(SETTLE + 1);

   typedef enum logic {ARB_IDLE, ARB_SETTLE} dcmw_arb_t;

   dcmw_cable_t       cable_s;
   logic [EV_N-1:0]   evt_d;
   logic [EV_N-1:0]   rx_evt;
   logic [EV_N-1:0]   tx_evt;
   logic [EV_N-1:0]   tx_tog;
   logic [DATA_W-1:0] tx_data;
   logic [DATA_W-1:0] acc;
   logic [DATA_W-1:0] buf_q;
   logic              link_busy;
   logic              link_done;
   logic              wdt_done;
   logic              wdt_running;
   logic              wdt_expire;
   logic              wdt_start;
   dcmw_arb_t         arb_state;
   logic [SW-1:0]     arb_cnt;
   logic              arb_req;
   logic              arb_decide;
   logic              arb_grant;
   logic [INT_N-1:0]  int_stat;
   logic [INT_N-1:0]  int_mask;
   logic [INT_N-1:0]  flag_now;
   logic [INT_N-1:0]  flag_d;
   logic [INT_N-1:0]  w1c;
   logic [5:0]        int_src;
   logic              apb_wr;
   logic              hit;
   logic [31:0]       rd_mux;
   dcmw_cmd_t         cmd;
   logic              exec;
   logic              is_link;
   logic              is_wdt;
   logic              link_rd;
   logic              link_wr;
   logic              link_clrf;
   logic              wdt_own;
   dcmw_fn_t          link_fn;
   dcmw_fn_t          wdt_fn;

   // ---------------------------------------------------------------
   // Cable input crossing
   // ---------------------------------------------------------------
   dcmw_sync #(
      .W ($bits(dcmw_cable_t))
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (cable_in),
      .q       (cable_s)
   );

   // Last synchronised toggles, so each change gives a one-cycle event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_d <= '0;
      end else begin
         evt_d <= cable_s.evt;
      end
   end

   assign rx_evt = cable_s.evt ^ evt_d;

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // Zero-wait slave; read data is latched in the setup cycle
   assign pready = 1'b1;
   assign apb_wr = psel && penable && pwrite;

   // Address decode and read mux
   always_comb begin
      hit    = 1'b1;
      rd_mux = '0;
      unique case (paddr)
         OFS_ACC:      rd_mux[DATA_W-1:0] = acc;
         OFS_CMD:      rd_mux = '0;
         OFS_FLAGS: begin
            rd_mux[FLG_BUSY]      = link_busy;
            rd_mux[FLG_DONE]      = link_done;
            rd_mux[FLG_WDT_DONE]  = wdt_done;
            rd_mux[FLG_WDT_RUN]   = wdt_running;
            rd_mux[FLG_PENDING]   = arb_state != ARB_IDLE;
            rd_mux[FLG_PEER_BUSY] = cable_s.busy;
         end
         OFS_BUF:      rd_mux[DATA_W-1:0] = buf_q;
         OFS_INT_STAT: rd_mux[INT_N-1:0] = int_stat;
         OFS_INT_MASK: rd_mux[INT_N-1:0] = int_mask;
         OFS_INT_SRC:  rd_mux[5:0] = int_src;
         default:      hit = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && !hit;

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable) begin
         prdata <= rd_mux;
      end
   end

   // ---------------------------------------------------------------
   // Instruction decode
   // ---------------------------------------------------------------
   // Commands written while an arbitration is open are dropped
   assign cmd       = dcmw_cmd_t'(pwdata[CMD_W-1:0]);
   assign exec      = apb_wr && (paddr == OFS_CMD) && (arb_state == ARB_IDLE);
   assign is_link   = exec && (cmd.dev == DEV_LINK);
   assign is_wdt    = exec && (cmd.dev == DEV_WDT);   // [RULE17]
   assign link_rd   = is_link && (cmd.op == OP_READ);
   assign link_wr   = is_link && (cmd.op == OP_WRITE);
   assign link_clrf = is_link && (cmd.op == OP_CLRF);
   assign wdt_own   = is_wdt && (cmd.op == OP_WRITE);  // [RULE12]

   // Function is ignored on clear-flags rather than left undefined
   assign link_fn = (is_link && !link_clrf) ? cmd.fn : FN_NONE;  // [RULE3]
   assign wdt_fn  = is_wdt ? cmd.fn : FN_NONE;

   // ---------------------------------------------------------------
   // Accumulator and shared buffer
   // ---------------------------------------------------------------
   // Accumulator: host writes, read-data loads, clear-flags wipes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= '0;
      end else if (apb_wr && (paddr == OFS_ACC)) begin
         acc <= pwdata[DATA_W-1:0];
      end else if (link_rd) begin
         acc <= buf_q;                                // [RULE1]
      end else if (link_clrf) begin
         acc <= '0;                                   // [RULE4]
      end
   end

   // Local copy of the shared word; a local write beats a peer word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_q <= '0;
      end else if (link_wr) begin
         buf_q <= acc;                                // [RULE2]
      end else if (rx_evt[EV_BUF]) begin
         buf_q <= cable_s.data;
      end
   end

   // Word mirrored to the peer's copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_data <= '0;
      end else if (link_wr) begin
         tx_data <= acc;                              // [RULE2]
      end
   end

   // ---------------------------------------------------------------
   // Events to the peer, one toggle each
   // ---------------------------------------------------------------
   assign tx_evt[EV_BUF]    = link_wr;
   assign tx_evt[EV_BCLR]   = link_fn == FN_CLEAR;     // [RULE15]
   assign tx_evt[EV_DSET]   = link_fn == FN_PULSE;     // [RULE15]
   assign tx_evt[EV_WSTART] = wdt_fn == FN_START;      // [RULE7]
   assign tx_evt[EV_WSET]   = wdt_fn == FN_PULSE;      // [RULE11]

   // Toggles survive the crossing where short pulses would not
   for (genvar i = 0; i < EV_N; i++) begin : g_tog
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            tx_tog[i] <= 1'b0;
         end else if (tx_evt[i]) begin
            tx_tog[i] <= ~tx_tog[i];
         end
      end
   end

   assign cable_out.data = tx_data;
   assign cable_out.evt  = tx_tog;
   assign cable_out.busy = link_busy;
   assign cable_out.req  = arb_req;

   // ---------------------------------------------------------------
   // Busy arbitration
   // ---------------------------------------------------------------
   // Both ends may start together; the request stays up long enough
   // for each to see the other, and the static winner breaks the tie
   assign arb_decide = (arb_state == ARB_SETTLE) && (arb_cnt == '0);
   assign arb_grant  = arb_decide && !cable_s.busy
                       && !(cable_s.req && !ARB_WINS);  // [RULE14]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arb_state <= ARB_IDLE;
         arb_cnt   <= '0;
         arb_req   <= 1'b0;
      end else begin
         unique case (arb_state)
            ARB_IDLE: begin
               if (link_fn == FN_START) begin
                  arb_state <= ARB_SETTLE;
                  arb_cnt   <= SW'(SETTLE - 1);
                  arb_req   <= 1'b1;
               end
            end
            ARB_SETTLE: begin
               if (arb_decide) begin
                  arb_state <= ARB_IDLE;
                  arb_req   <= 1'b0;
               end else begin
                  arb_cnt <= arb_cnt - 1'b1;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Half-duplex flags
   // ---------------------------------------------------------------
   // Busy: a grant wins over any clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_busy <= 1'b0;
      end else if (arb_grant) begin
         link_busy <= 1'b1;                           // [RULE14]
      end else if (link_clrf || rx_evt[EV_BCLR]) begin
         link_busy <= 1'b0;                           // [RULE4] [RULE15]
      end
   end

   // Done: a peer pulse wins over a local clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_done <= 1'b0;
      end else if (rx_evt[EV_DSET]) begin
         link_done <= 1'b1;                           // [RULE15]
      end else if (link_clrf || link_fn == FN_CLEAR || link_fn == FN_PULSE) begin
         link_done <= 1'b0;                           // [RULE3] [RULE4]
      end
   end

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   assign wdt_start = rx_evt[EV_WSTART] || wdt_own;   // [RULE7] [RULE12]

   dcmw_wdt #(
      .CYCLES (WDT_CYCLES)
   ) u_wdt (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (wdt_start),
      .running (wdt_running),
      .expire  (wdt_expire)
   );

   // Watchdog done holds until the local host clears it; sets win
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_done <= 1'b0;
      end else if (wdt_expire || rx_evt[EV_WSET]) begin
         wdt_done <= 1'b1;                            // [RULE8] [RULE11]
      end else if (wdt_fn == FN_CLEAR) begin
         wdt_done <= 1'b0;                            // [RULE9] [RULE10]
      end
   end

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   assign flag_now[INT_LINK] = link_done;
   assign flag_now[INT_WDT]  = wdt_done;
   assign w1c = (apb_wr && paddr == OFS_INT_STAT) ? pwdata[INT_N-1:0] : '0;

   // Status: set on a flag rising, dropped by W1C or when the flag goes;
   // the rise wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_d   <= '0;
         int_stat <= '0;
      end else begin
         flag_d   <= flag_now;
         int_stat <= (int_stat & ~w1c & flag_now) | (flag_now & ~flag_d);  // [RULE6] [RULE18]
      end
   end

   // Mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask <= MASK_RST;
      end else if (apb_wr && paddr == OFS_INT_MASK) begin
         int_mask <= pwdata[INT_N-1:0];
      end
   end

   // Interrupt line, one cycle behind the status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat & int_mask);               // [RULE6]
      end
   end

   // Source code of the highest-ranked pending bit
   always_comb begin
      int_src = DEV_NONE;
      if (int_stat[INT_LINK] && int_mask[INT_LINK]) begin
         int_src = DEV_LINK;                          // [RULE16]
      end else if (int_stat[INT_WDT] && int_mask[INT_WDT]) begin
         int_src = DEV_WDT;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_start;
      (link_fn == FN_START) && (arb_state == ARB_IDLE);
   endsequence

   sequence s_settle;
      arb_req [*4] ##1 !arb_req;
   endsequence

   a_read_copy: assert property (link_rd && !rx_evt[EV_BUF] |=> acc == $past(buf_q) && $stable(buf_q)) // [RULE1]
      else $error("read did not copy buffer");
   a_write_load: assert property (link_wr |=> buf_q == $past(acc) && $stable(acc)) // [RULE2]
      else $error("write did not load buffer");
   a_clrf_flags: assert property (link_clrf && !rx_evt[EV_DSET] |=> !link_busy && !link_done) // [RULE4]
      else $error("clear-flags left a flag set");
   a_pulse_peer: assert property (link_fn == FN_PULSE && !rx_evt[EV_DSET]
      |=> !link_done && tx_tog[EV_DSET] != $past(tx_tog[EV_DSET])) // [RULE15]
      else $error("pulse did not reach peer");
   a_start_window: assert property (s_start |=> s_settle) // [RULE14]
      else $error("arbitration window wrong length");
   a_busy_refused: assert property (arb_decide && cable_s.busy && !link_busy |=> !link_busy) // [RULE14]
      else $error("busy taken while peer busy");
   a_wdt_expire: assert property (wdt_expire |=> wdt_done ##1 int_stat[INT_WDT]) // [RULE8]
      else $error("expiry did not set done");
   a_wdt_hold: assert property (wdt_done && wdt_fn != FN_CLEAR |=> wdt_done) // [RULE9]
      else $error("watchdog done dropped alone");
   a_wdt_clear: assert property (wdt_fn == FN_CLEAR && !wdt_expire && !rx_evt[EV_WSET]
      |=> !wdt_done ##1 !int_stat[INT_WDT]) // [RULE10]
      else $error("clear did not drop done");
   a_peer_set: assert property (rx_evt[EV_WSET] |=> wdt_done) // [RULE11]
      else $error("peer pulse did not set done");
   a_wdt_restart: assert property (wdt_start |=> wdt_running) // [RULE7]
      else $error("restart did not run timer");
   a_dev_select: assert property (exec && cmd.dev != DEV_LINK && cmd.dev != DEV_WDT && !rx_evt[EV_BUF]
      |=> $stable(acc) && $stable(buf_q) && $stable(tx_tog)) // [RULE17]
      else $error("foreign code had effect");
   a_int_order: assert property (int_stat[INT_LINK] && int_mask[INT_LINK]
      |-> int_src == DEV_LINK) // [RULE16]
      else $error("line interrupt not first");

endmodule : dcmw_link

// [tb/dcmw_peer.sv]
// Behavioural far-end board: event toggles, a held word, a busy level.
// Assumes the bench pulses ev for one clock per wanted event.
`timescale 1ns/1ps
module dcmw_peer
   import dcmw_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [EV_N-1:0]   ev,
   input  wire logic [DATA_W-1:0] word,
   input  wire logic              busy,
   input  wire logic              alive,
   output dcmw_cable_t            to_dut
);
   logic [5:0] tick;
   // Toggles, not pulses, so a slow far end never misses one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_dut <= '0;
         tick   <= '0;
      end else begin
         tick        <= tick + 6'h01;
         to_dut.evt  <= to_dut.evt ^ ev ^ {1'b0, alive && tick == 6'h00, 3'h0};
         to_dut.data <= word;
         to_dut.busy <= busy;
         to_dut.req  <= busy;   // Busy peer also contends
      end
   end
endmodule : dcmw_peer

// [tb/tb.sv]
// Self-checking bench for one link end against the behavioural peer.
// Assumes zero-wait APB and a short watchdog period for simulation.
`timescale 1ns/1ps
module tb;
   import dcmw_pkg::*;
   localparam int unsigned WDT = 80;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, busy, alive, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [EV_N-1:0]   ev, e0;
   logic [DATA_W-1:0] word, r;
   dcmw_cable_t       c_out, c_in;
   int                n_fail, comparisons, cyc;

   dcmw_link #(.WDT_CYCLES(WDT)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .cable_out(c_out), .cable_in(c_in));
   dcmw_peer i_peer (.pclk(pclk), .presetn(presetn), .ev(ev), .word(word), .busy(busy),
      .alive(alive), .to_dut(c_in));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Hang guard, well above the planned run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end

   task automatic conclude();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   // Toggles a command should send to the peer
   function automatic logic [EV_N-1:0] exp_ev(input logic [1:0] fn, input logic [1:0] op,
                                              input logic [5:0] dev);
      exp_ev = '0;
      if (dev == DEV_LINK && op != OP_CLRF) begin
         exp_ev[EV_BUF]  = (op == OP_WRITE);
         exp_ev[EV_BCLR] = (fn == FN_CLEAR);
         exp_ev[EV_DSET] = (fn == FN_PULSE);
      end else if (dev == DEV_WDT) begin
         exp_ev[EV_WSTART] = (fn == FN_START);
         exp_ev[EV_WSET]   = (fn == FN_PULSE);
      end
   endfunction : exp_ev

   // Edge first, so two calls never drive psel twice in one step
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc

   task automatic fl(input int b, input logic e);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk({31'h0, rd[b]}, {31'h0, e});
   endtask : fl

   task automatic cmd(input logic [1:0] fn, input logic [1:0] op, input logic [5:0] dev);
      e0 = c_out.evt;
      apb(1'b1, OFS_CMD, {22'h0, fn, op, dev});
      repeat (2) @(posedge pclk);
   endtask : cmd

   task automatic pev(input int i);
      @(posedge pclk) ev <= 5'h01 << i;
      @(posedge pclk) ev <= '0;
      repeat (8) @(posedge pclk);
   endtask : pev

   initial begin
      {psel, penable, pwrite, busy, alive} = '0;
      paddr = '0; pwdata = '0; ev = '0; word = '0; presetn = 1'b0;
      n_fail = 0; comparisons = 0; cyc = 0;
      r = 16'($urandom(32'h1E0141D1));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdc(OFS_FLAGS, 32'h0);
      // Word exchange both ways with random data
      repeat (4) begin
         r = 16'($urandom);
         apb(1'b1, OFS_ACC, {16'h0, r});
         cmd(FN_NONE, OP_WRITE, DEV_LINK);
         rdc(OFS_BUF, {16'h0, r});
         rdc(OFS_ACC, {16'h0, r});
         chk({16'h0, c_out.data}, {16'h0, r});
         word <= ~r;
         pev(EV_BUF);
         cmd(FN_NONE, OP_READ, DEV_LINK);
         rdc(OFS_ACC, {16'h0, ~r});
         rdc(OFS_BUF, {16'h0, ~r});
      end
      // Interlock: win when peer idle, lose when peer busy
      cmd(FN_START, OP_NIO, DEV_LINK);
      chk({31'h0, c_out.req}, 32'h1);
      repeat (8) @(posedge pclk);
      fl(FLG_BUSY, 1'b1);
      chk({31'h0, c_out.busy}, 32'h1);
      busy <= 1'b1;
      cmd(FN_NONE, OP_CLRF, DEV_LINK);
      rdc(OFS_ACC, 32'h0);
      fl(FLG_BUSY, 1'b0);
      fl(FLG_PEER_BUSY, 1'b1);
      cmd(FN_START, OP_NIO, DEV_LINK);
      fl(FLG_PENDING, 1'b1);
      repeat (8) @(posedge pclk);
      fl(FLG_BUSY, 1'b0);
      busy <= 1'b0;
      // Done from peer, interrupt, then pulse and clear functions
      apb(1'b1, OFS_INT_MASK, 32'h3);
      pev(EV_DSET);
      fl(FLG_DONE, 1'b1);
      chk({31'h0, irq}, 32'h1);
      rdc(OFS_INT_SRC, {26'h0, DEV_LINK});
      cmd(FN_PULSE, OP_WRITE, DEV_LINK);
      fl(FLG_DONE, 1'b0);
      chk({27'h0, c_out.evt}, {27'h0, e0 ^ exp_ev(FN_PULSE, OP_WRITE, DEV_LINK)});
      cmd(FN_CLEAR, OP_READ, DEV_LINK);
      chk({27'h0, c_out.evt}, {27'h0, e0 ^ exp_ev(FN_CLEAR, OP_READ, DEV_LINK)});
      chk({31'h0, irq}, 32'h0);
      // Watchdog kept alive by the peer, then starved
      r = 16'($urandom);
      apb(1'b1, OFS_ACC, {16'h0, r});
      alive <= 1'b1;
      cmd(FN_NONE, OP_WRITE, DEV_WDT);
      rdc(OFS_ACC, {16'h0, r});
      fl(FLG_WDT_RUN, 1'b1);
      repeat (300) @(posedge pclk);
      fl(FLG_WDT_DONE, 1'b0);
      alive <= 1'b0;
      repeat (WDT + 80) @(posedge pclk);
      fl(FLG_WDT_DONE, 1'b1);
      chk({31'h0, irq}, 32'h1);
      rdc(OFS_INT_SRC, {26'h0, DEV_WDT});
      repeat (200) @(posedge pclk);
      fl(FLG_WDT_DONE, 1'b1);
      cmd(FN_CLEAR, OP_NIO, DEV_WDT);
      fl(FLG_WDT_DONE, 1'b0);
      chk({31'h0, irq}, 32'h0);
      cmd(FN_START, OP_NIO, DEV_WDT);
      chk({27'h0, c_out.evt}, {27'h0, e0 ^ exp_ev(FN_START, OP_NIO, DEV_WDT)});
      cmd(FN_PULSE, OP_NIO, DEV_WDT);
      chk({27'h0, c_out.evt}, {27'h0, e0 ^ exp_ev(FN_PULSE, OP_NIO, DEV_WDT)});
      pev(EV_WSET);
      fl(FLG_WDT_DONE, 1'b1);
      cmd(FN_PULSE, OP_NIO, 6'h1D);
      chk({27'h0, c_out.evt}, {27'h0, e0 ^ exp_ev(FN_PULSE, OP_NIO, 6'h1D)});
      apb(1'b0, 12'h0FC, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      conclude();
   end
endmodule : tb
